/* include/xwc_pkg.sv */
// shared constants and types for the extended write command block
package xwc_pkg;
  // taskfile addresses
  localparam logic [3:0] TF_DATA   = 4'h0;
  localparam logic [3:0] TF_FEAT   = 4'h1;
  localparam logic [3:0] TF_SCNT   = 4'h2;
  localparam logic [3:0] TF_SNUM   = 4'h3;
  localparam logic [3:0] TF_CYLL   = 4'h4;
  localparam logic [3:0] TF_CYLH   = 4'h5;
  localparam logic [3:0] TF_DEVH   = 4'h6;
  localparam logic [3:0] TF_CMD    = 4'h7;
  localparam logic [3:0] TF_DEVCTL = 4'he;
  localparam int         HOB_BIT   = 7;
  // commands and feature bits
  localparam logic [7:0] CMD_WSE   = 8'h34;
  localparam logic [7:0] CMD_WSTR  = 8'h3a;
  localparam int         FT_WC     = 6;
  localparam int         FT_FLUSH  = 5;
  localparam logic [7:0] DEVH_LBA  = 8'h40;
  // status and error bits
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_SE  = 5;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_CRC = 7;
  localparam int ER_IDN = 4;
  localparam int ER_ABT = 2;
  localparam int ER_TO  = 0;
  localparam logic [7:0] STAT_RST = 8'h50;
  localparam logic [7:0] ERR_RST  = 8'h00;
  // sizes and timing
  localparam logic [7:0]  SEC_LAST_W = 8'hff;
  localparam logic [16:0] CNT_ZERO   = 17'h10000;
  localparam int          CLK_NS     = 20;
  localparam int          CCTL_US    = 100000;
  localparam int          CCTL_CYC   = CCTL_US * 1000 / CLK_NS;
  // host wishbone map
  localparam logic [7:0] WB_CTRL  = 8'h00;
  localparam logic [7:0] WB_LBALO = 8'h04;
  localparam logic [7:0] WB_LBAHI = 8'h08;
  localparam logic [7:0] WB_COUNT = 8'h0c;
  localparam logic [7:0] WB_FEAT  = 8'h10;
  localparam logic [7:0] WB_DATA  = 8'h14;
  localparam logic [7:0] WB_STAT  = 8'h18;
  localparam logic [7:0] WB_FLO   = 8'h1c;
  localparam logic [7:0] WB_FHI   = 8'h20;
  localparam logic [7:0] WB_ISTAT = 8'h24;
  localparam logic [7:0] WB_IMASK = 8'h28;
  localparam int         CTRL_GO  = 8;
  localparam logic [3:0] LAST_ISSUE = 4'hb;
  localparam logic [3:0] LAST_RB    = 4'h9;

  typedef enum logic [3:0] {
    XWC_D_IDLE  = 4'b0001,
    XWC_D_PIO   = 4'b0010,
    XWC_D_DMA   = 4'b0100,
    XWC_D_FLUSH = 4'b1000
  } xwc_dst_t;

  typedef enum logic [3:0] {
    XWC_H_IDLE  = 4'b0001,
    XWC_H_ISSUE = 4'b0010,
    XWC_H_RUN   = 4'b0100,
    XWC_H_RB    = 4'b1000
  } xwc_hst_t;
endpackage : xwc_pkg

/* include/xwc_if.sv */
// taskfile and dma link between host adapter and device
`timescale 1ns/10ps
interface xwc_if;
  logic        tf_wr;
  logic [3:0]  tf_addr;
  logic [15:0] tf_wdata;
  logic [15:0] tf_rdata;
  logic [7:0]  tf_stat;
  logic        dmarq;
  logic        dma_wr;
  logic        intrq;

  modport dev (
    input  tf_wr, tf_addr, tf_wdata, dma_wr,
    output tf_rdata, tf_stat, dmarq, intrq
  );
  modport hst (
    output tf_wr, tf_addr, tf_wdata, dma_wr,
    input  tf_rdata, tf_stat, dmarq, intrq
  );
endinterface : xwc_if

/* src/xwc_dev.sv */
// device end: taskfile registers, write command sequencing, error reporting
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
module xwc_dev
  import xwc_pkg::*;
#(
  parameter int unsigned CCTL_CYCLES = CCTL_CYC
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // link to host
  xwc_if.dev               lnk,
  // media side
  input  wire logic        media_err_i,
  input  wire logic        flush_done_i,
  output logic             media_we_o,
  output logic [47:0]      media_lba_o,
  output logic [15:0]      media_data_o,
  output logic             flush_req_o,
  output logic [2:0]       stream_identifier_o
);

  typedef struct packed {
    xwc_dst_t       st;
    logic [5:1][7:0] cur;
    logic [5:1][7:0] prv;
    logic           high_byte_select;
    logic [7:0]     err;
    logic [7:0]     stat;
    logic [16:0]    left;
    logic [7:0]     wcnt;
    logic [47:0]    lba;
    logic [31:0]    tmr;
    logic [15:0]    rdata;
    logic           dmarq;
    logic           intrq;
    logic           mwe;
    logic [47:0]    mlba;
    logic [15:0]    mdata;
    logic           flush;
    logic [2:0]     sid;
    logic           wc;
    logic           fl;
    logic           se;
  } xwc_dstate_t;

  xwc_dstate_t q_r;
  xwc_dstate_t q_nxt;

  always_comb begin
    logic        word;
    logic        fin;
    logic        ferr;
    logic        tout;
    logic [16:0] cnt;
    int          a;
    word = 1'b0;
    fin  = 1'b0;
    ferr = 1'b0;
    tout = 1'b0;
    cnt  = 17'h0;
    a    = int'(lnk.tf_addr);
    q_nxt = q_r;
    q_nxt.mwe = 1'b0;

    // register writes from the host
    if (lnk.tf_wr) begin
      if (lnk.tf_addr >= TF_FEAT && lnk.tf_addr <= TF_CYLH &&
          q_r.st == XWC_D_IDLE) begin
        q_nxt.prv[a] = q_r.cur[a];
        q_nxt.cur[a] = lnk.tf_wdata[7:0];
      end
      if (lnk.tf_addr == TF_DEVCTL) begin
        q_nxt.high_byte_select = lnk.tf_wdata[HOB_BIT];
      end
      // commands are ignored while busy
      if (lnk.tf_addr == TF_CMD && q_r.st == XWC_D_IDLE) begin
        cnt = {1'b0, q_r.prv[2], q_r.cur[2]};
        q_nxt.left  = (cnt == 17'h0) ? CNT_ZERO : cnt;
        q_nxt.lba   = {q_r.prv[5], q_r.prv[4], q_r.prv[3],
                       q_r.cur[5], q_r.cur[4], q_r.cur[3]};
        q_nxt.wcnt  = 8'h0;
        q_nxt.tmr   = 32'h0;
        q_nxt.err   = ERR_RST;
        q_nxt.se    = 1'b0;
        q_nxt.intrq = 1'b0;
        q_nxt.stat  = 8'h0;
        q_nxt.stat[ST_RDY] = 1'b1;
        q_nxt.stat[ST_DSC] = 1'b1;
        if (lnk.tf_wdata[7:0] == CMD_WSE) begin
          q_nxt.st = XWC_D_PIO;
          q_nxt.wc = 1'b0;
          q_nxt.fl = 1'b0;
          q_nxt.stat[ST_BSY] = 1'b1;
          q_nxt.stat[ST_DRQ] = 1'b1;
        end else if (lnk.tf_wdata[7:0] == CMD_WSTR) begin
          q_nxt.st    = XWC_D_DMA;
          q_nxt.wc    = q_r.cur[1][FT_WC];
          q_nxt.fl    = q_r.cur[1][FT_FLUSH];
          q_nxt.sid   = q_r.cur[1][2:0];
          q_nxt.dmarq = 1'b1;
          q_nxt.stat[ST_BSY] = 1'b1;
          q_nxt.stat[ST_DSC] = 1'b0;
        end else begin
          // unknown opcode aborts at once
          q_nxt.err[ER_ABT]  = 1'b1;
          q_nxt.stat[ST_ERR] = 1'b1;
          q_nxt.intrq        = 1'b1;
        end
      end
    end

    // data words, one 16-bit word per strobe
    if (q_r.st == XWC_D_PIO) begin
      word = lnk.tf_wr && lnk.tf_addr == TF_DATA;
    end
    if (q_r.st == XWC_D_DMA) begin
      word = lnk.dma_wr;
    end
    if (word) begin
      q_nxt.mwe   = 1'b1;
      q_nxt.mlba  = q_r.lba;
      q_nxt.mdata = lnk.tf_wdata;
      q_nxt.wcnt  = q_r.wcnt + 8'h1;
      if (media_err_i && !q_r.wc) begin
        // first failure ends the command; address kept for readback
        fin  = 1'b1;
        ferr = 1'b1;
        q_nxt.err[ER_ABT] = 1'b1;
        q_nxt.err[ER_IDN] = 1'b1;
        {q_nxt.prv[5], q_nxt.prv[4], q_nxt.prv[3],
         q_nxt.cur[5], q_nxt.cur[4], q_nxt.cur[3]} = q_r.lba;
      end else begin
        if (media_err_i) begin
          // logged only; transfer runs on to the full count
          q_nxt.err[ER_IDN] = 1'b1;
          q_nxt.se = 1'b1;
        end
        if (q_r.wcnt == SEC_LAST_W) begin
          q_nxt.lba  = q_r.lba + 48'h1;
          q_nxt.left = q_r.left - 17'h1;
          fin = (q_r.left == 17'h1);
        end
      end
    end

    // completion time limit on the stream write
    if (q_r.st == XWC_D_DMA || q_r.st == XWC_D_FLUSH) begin
      q_nxt.tmr = q_r.tmr + 32'h1;
      if (q_r.tmr == 32'(CCTL_CYCLES - 1)) begin
        tout = 1'b1;
      end
    end
    if (tout && !fin) begin
      fin = 1'b1;
      if (q_r.wc) begin
        q_nxt.err[ER_TO] = 1'b1;
        q_nxt.se = 1'b1;
      end else begin
        ferr = 1'b1;
        q_nxt.err[ER_ABT] = 1'b1;
      end
    end

    // flush holds completion until the media side confirms
    if (q_r.st == XWC_D_FLUSH && flush_done_i && !tout) begin
      fin = 1'b1;
    end
    if (fin && q_r.st == XWC_D_DMA && q_r.fl && !ferr && !tout) begin
      q_nxt.st    = XWC_D_FLUSH;
      q_nxt.flush = 1'b1;
      q_nxt.dmarq = 1'b0;
      fin = 1'b0;
    end

    // final status: busy drops together with error and stream flags
    if (fin) begin
      q_nxt.st    = XWC_D_IDLE;
      q_nxt.dmarq = 1'b0;
      q_nxt.flush = 1'b0;
      q_nxt.intrq = 1'b1;
      q_nxt.stat[ST_BSY] = 1'b0;
      q_nxt.stat[ST_DRQ] = 1'b0;
      q_nxt.stat[ST_ERR] = ferr;
      if (q_r.st != XWC_D_PIO) begin
        q_nxt.stat[ST_SE] = q_nxt.se;
      end
    end

    // read data follows the address presented one cycle before
    unique case (lnk.tf_addr)
      TF_FEAT:  q_nxt.rdata = {8'h0, q_nxt.err};
      TF_CMD:   q_nxt.rdata = {8'h0, q_nxt.stat};
      TF_SCNT, TF_SNUM, TF_CYLL, TF_CYLH: begin
        q_nxt.rdata = {8'h0, q_r.high_byte_select ? q_nxt.prv[a] : q_nxt.cur[a]};
      end
      default:  q_nxt.rdata = 16'h0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_r      <= '0;
      q_r.st   <= XWC_D_IDLE;
      q_r.stat <= STAT_RST;
      q_r.err  <= ERR_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign lnk.tf_rdata = q_r.rdata;
  assign lnk.tf_stat  = q_r.stat;
  assign lnk.dmarq    = q_r.dmarq;
  assign lnk.intrq    = q_r.intrq;
  assign media_we_o   = q_r.mwe;
  assign media_lba_o  = q_r.mlba;
  assign media_data_o = q_r.mdata;
  assign flush_req_o  = q_r.flush;
  assign stream_identifier_o  = q_r.sid;

endmodule : xwc_dev

/* src/xwc_hst.sv */
// host end: wishbone command registers driving the taskfile link
`timescale 1ns/10ps
module xwc_hst
  import xwc_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // interrupt
  output logic             irq_o,
  // link to device
  xwc_if.hst               lnk
);

  typedef struct packed {
    xwc_hst_t    st;
    logic [3:0]  step;
    logic [7:0]  opc;
    logic [47:0] lba;
    logic [15:0] cnt;
    logic [15:0] feat;
    logic [47:0] fail;
    logic [1:0]  ist;
    logic [1:0]  imsk;
    logic        ack;
    logic [31:0] dat;
    logic        irq;
    logic        wr;
    logic        dwr;
    logic [3:0]  addr;
    logic [15:0] wdat;
  } xwc_hstate_t;

  xwc_hstate_t q_r;
  xwc_hstate_t q_nxt;

  always_comb begin
    logic        req;
    logic        rdy;
    logic [1:0]  ev;
    logic [15:0] pv;
    logic [15:0] cv;
    req = wb_cyc_i && wb_stb_i && !q_r.ack;
    rdy = q_r.opc == CMD_WSE ? lnk.tf_stat[ST_DRQ] : lnk.dmarq;
    ev  = 2'b00;
    pv  = 16'h0;
    cv  = 16'h0;
    q_nxt = q_r;
    q_nxt.ack = 1'b0;
    q_nxt.wr  = 1'b0;
    q_nxt.dwr = 1'b0;

    // wishbone access; data words wait for the device to be ready
    if (req && !(wb_we_i && wb_adr_i == WB_DATA && !rdy)) begin
      q_nxt.ack = 1'b1;
      q_nxt.dat = 32'h0;
      if (wb_we_i) begin
        unique case (wb_adr_i)
          WB_CTRL: if (wb_dat_i[CTRL_GO] && q_r.st == XWC_H_IDLE) begin
            q_nxt.opc  = wb_dat_i[7:0];
            q_nxt.st   = XWC_H_ISSUE;
            q_nxt.step = 4'h0;
          end
          WB_LBALO: q_nxt.lba[31:0]  = wb_dat_i;
          WB_LBAHI: q_nxt.lba[47:32] = wb_dat_i[15:0];
          WB_COUNT: q_nxt.cnt  = wb_dat_i[15:0];
          WB_FEAT:  q_nxt.feat = wb_dat_i[15:0];
          WB_DATA: begin
            q_nxt.wdat = wb_dat_i[15:0];
            q_nxt.addr = TF_DATA;
            q_nxt.wr   = q_r.opc == CMD_WSE;
            q_nxt.dwr  = q_r.opc != CMD_WSE;
          end
          WB_IMASK: q_nxt.imsk = wb_dat_i[1:0];
          default:  q_nxt.dat = 32'h0;
        endcase
      end else begin
        unique case (wb_adr_i)
          WB_CTRL:  q_nxt.dat = {23'h0, q_r.st != XWC_H_IDLE, q_r.opc};
          WB_LBALO: q_nxt.dat = q_r.lba[31:0];
          WB_LBAHI: q_nxt.dat = {16'h0, q_r.lba[47:32]};
          WB_COUNT: q_nxt.dat = {16'h0, q_r.cnt};
          WB_FEAT:  q_nxt.dat = {16'h0, q_r.feat};
          WB_STAT:  q_nxt.dat = {24'h0, lnk.tf_stat};
          WB_FLO:   q_nxt.dat = q_r.fail[31:0];
          WB_FHI:   q_nxt.dat = {16'h0, q_r.fail[47:32]};
          WB_ISTAT: q_nxt.dat = {30'h0, q_r.ist};
          WB_IMASK: q_nxt.dat = {30'h0, q_r.imsk};
          default:  q_nxt.dat = 32'h0;
        endcase
      end
    end

    // load the taskfile: previous half first, then current
    pv = {q_r.feat[15:8], q_r.cnt[15:8]};
    cv = {q_r.feat[7:0], q_r.cnt[7:0]};
    if (q_r.st == XWC_H_ISSUE) begin
      q_nxt.wr   = 1'b1;
      q_nxt.step = q_r.step + 4'h1;
      q_nxt.addr = TF_FEAT + {1'b0, q_r.step[3:1]};
      unique case (q_r.step[3:1])
        3'h0: q_nxt.wdat = {8'h0, q_r.step[0] ? cv[15:8] : pv[15:8]};
        3'h1: q_nxt.wdat = {8'h0, q_r.step[0] ? cv[7:0] : pv[7:0]};
        3'h2: q_nxt.wdat = {8'h0, q_r.step[0] ? q_r.lba[7:0] : q_r.lba[31:24]};
        3'h3: q_nxt.wdat = {8'h0, q_r.step[0] ? q_r.lba[15:8] : q_r.lba[39:32]};
        3'h4: q_nxt.wdat = {8'h0, q_r.step[0] ? q_r.lba[23:16] : q_r.lba[47:40]};
        default: begin
          q_nxt.addr = q_r.step[0] ? TF_CMD : TF_DEVH;
          q_nxt.wdat = {8'h0, q_r.step[0] ? q_r.opc : DEVH_LBA};
        end
      endcase
      if (q_r.step == LAST_ISSUE) begin
        q_nxt.st   = XWC_H_RUN;
        q_nxt.step = 4'h0;
      end
    end

    // on completion gather the 48-bit failing address, low half first;
    // first run cycle still shows intrq of the previous command, so skip it
    if (q_r.st == XWC_H_RUN) begin
      q_nxt.step = 4'h1;
      if (q_r.step != 4'h0 && lnk.intrq && !lnk.tf_stat[ST_BSY]) begin
        q_nxt.st   = XWC_H_RB;
        q_nxt.step = 4'h0;
      end
    end
    if (q_r.st == XWC_H_RB) begin
      q_nxt.step = q_r.step + 4'h1;
      q_nxt.wr   = q_r.step == 4'h0 || q_r.step == 4'h4;
      q_nxt.wdat = {8'h0, q_r.step == 4'h4, 7'h0};
      unique case (q_r.step)
        4'h0, 4'h4: q_nxt.addr = TF_DEVCTL;
        4'h1, 4'h5: q_nxt.addr = TF_SNUM;
        4'h2, 4'h6: q_nxt.addr = TF_CYLL;
        default:    q_nxt.addr = TF_CYLH;
      endcase
      // read data lags the address by two cycles
      if (q_r.step >= 4'h3 && q_r.step != 4'h6) begin
        q_nxt.fail = {lnk.tf_rdata[7:0], q_r.fail[47:8]};
      end
      if (q_r.step == LAST_RB) begin
        q_nxt.st = XWC_H_IDLE;
        ev[0] = 1'b1;
        ev[1] = lnk.tf_stat[ST_ERR] || lnk.tf_stat[ST_SE];
      end
    end

    // sticky events: a new event wins over a clearing write
    if (req && wb_we_i && wb_adr_i == WB_ISTAT) begin
      q_nxt.ist = q_r.ist & ~wb_dat_i[1:0];
    end
    q_nxt.ist = q_nxt.ist | ev;
    q_nxt.irq = |(q_nxt.ist & q_nxt.imsk);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_r    <= '0;
      q_r.st <= XWC_H_IDLE;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign wb_dat_o     = q_r.dat;
  assign wb_ack_o     = q_r.ack;
  assign irq_o        = q_r.irq;
  assign lnk.tf_wr    = q_r.wr;
  assign lnk.dma_wr   = q_r.dwr;
  assign lnk.tf_addr  = q_r.addr;
  assign lnk.tf_wdata = q_r.wdat;

endmodule : xwc_hst

/* test/xwc_chk_sva.sv */
// link checker: status, request and interrupt timing between the two ends
`timescale 1ns/10ps
module xwc_chk
  import xwc_pkg::*;
(
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  // link signals
  input wire logic        tf_wr,
  input wire logic [3:0]  tf_addr,
  input wire logic [15:0] tf_wdata,
  input wire logic [15:0] tf_rdata,
  input wire logic [7:0]  tf_stat,
  input wire logic        dmarq,
  input wire logic        dma_wr,
  input wire logic        intrq
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  wire cmd_ok;
  assign cmd_ok = tf_wr && tf_addr == TF_CMD && !tf_stat[ST_BSY];

  a_cmd_busy: assert property (cmd_ok && (tf_wdata[7:0] == CMD_WSE ||
    tf_wdata[7:0] == CMD_WSTR) |=> tf_stat[ST_BSY])
    else $error("busy not raised after command");
  a_pio_drq: assert property (cmd_ok && tf_wdata[7:0] == CMD_WSE
    |=> tf_stat[ST_DRQ] && !dmarq)
    else $error("sector write did not request words");
  a_dma_req: assert property (cmd_ok && tf_wdata[7:0] == CMD_WSTR
    |=> dmarq && !tf_stat[ST_DRQ])
    else $error("stream write did not request dma");
  a_final_irq: assert property ($fell(tf_stat[ST_BSY])
    |-> intrq && !dmarq && !tf_stat[ST_DRQ])
    else $error("final status without interrupt");
  a_se_clean: assert property (tf_stat[ST_SE] |-> !tf_stat[ST_ERR])
    else $error("stream error shown with err");
  a_err_stops: assert property (tf_stat[ST_ERR] |-> !tf_stat[ST_DRQ] && !dmarq)
    else $error("transfer continues after error");
  a_req_busy: assert property ((dmarq || tf_stat[ST_DRQ]) |-> tf_stat[ST_BSY])
    else $error("data request while not busy");
  a_irq_idle: assert property ($rose(intrq) |-> !tf_stat[ST_BSY] [*4])
    else $error("busy again right after completion");
  a_dma_gated: assert property (dma_wr |-> dmarq)
    else $error("dma word without request");
  a_reset_idle: assert property ($rose(nrst_i) |-> tf_stat == STAT_RST)
    else $error("status not idle after reset");
endmodule : xwc_chk

/* test/xwc_test.sv */
// self-checking bench: host and device ends joined over the link
`timescale 1ns/10ps
module xwc_test
  import xwc_pkg::*;
  ;
  localparam int CCTL = 2000;
  logic        mclk_i;
  logic        nrst_i;
  logic        cyc, stb, we, ack, irq, fl_done, m_we, fl_req;
  logic [7:0]  adr;
  logic [31:0] wdat, rd, dat_o;
  logic [47:0] m_lba, base;
  logic [15:0] m_data;
  logic [2:0]  sid;
  int          n_errors, comparisons, wcnt, err_idx;
  wire         m_err = (wcnt == err_idx);

  xwc_if lnk ();
  xwc_dev #(.CCTL_CYCLES(CCTL)) xwc_dev_inst (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .lnk(lnk.dev), .media_err_i(m_err), .flush_done_i(fl_done), .media_we_o(m_we),
    .media_lba_o(m_lba), .media_data_o(m_data), .flush_req_o(fl_req), .stream_identifier_o(sid));
  xwc_hst xwc_hst_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .irq_o(irq), .lnk(lnk.hst));
  xwc_chk xwc_chk_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .tf_wr(lnk.tf_wr),
    .tf_addr(lnk.tf_addr), .tf_wdata(lnk.tf_wdata), .tf_rdata(lnk.tf_rdata),
    .tf_stat(lnk.tf_stat), .dmarq(lnk.dmarq), .dma_wr(lnk.dma_wr), .intrq(lnk.intrq));

  task automatic test_done();
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; the wait is bounded since data writes stall on the device
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk_i);
      k++;
    end while (ack !== 1'b1 && k < 5000);
    if (k >= 5000) begin
      n_errors++;
      test_done();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk_i);
  endtask : wb

  task automatic wait_done();
    int k;
    k = 0;
    rd = '0;
    while (rd[0] !== 1'b1 && k < 3000) begin
      wb(WB_ISTAT, 1'b0, '0);
      k++;
    end
    if (k >= 3000) begin
      n_errors++;
      test_done();
    end
  endtask : wait_done

  task automatic issue(input logic [7:0] op, input logic [47:0] lba, input logic [15:0] n,
                       input logic [7:0] ft, input int e);
    wcnt = 0;
    base = lba;
    err_idx = e;
    wb(WB_ISTAT, 1'b1, 32'h3);
    wb(WB_LBALO, 1'b1, lba[31:0]);
    wb(WB_LBAHI, 1'b1, {16'h0, lba[47:32]});
    wb(WB_COUNT, 1'b1, {16'h0, n});
    wb(WB_FEAT, 1'b1, {24'h0, ft});
    wb(WB_CTRL, 1'b1, {23'h0, 1'b1, op});
  endtask : issue

  task automatic words(input int n);
    for (int i = 0; i < n; i++)
      wb(WB_DATA, 1'b1, 32'(i));
  endtask : words

  task automatic stat(input logic [7:0] exp);
    wb(WB_STAT, 1'b0, '0);
    chk(48'(rd[7:0] & 8'ha9), 48'(exp));
  endtask : stat

  // every word reaching the media: data in order, address per sector
  always @(posedge mclk_i) begin
    if (nrst_i === 1'b1 && m_we === 1'b1) begin
      chk(48'(m_data), 48'(wcnt[15:0]));
      chk(m_lba, base + 48'(wcnt / 256));
      wcnt <= wcnt + 1;
    end
  end

  task automatic t_regs();
    wb(WB_STAT, 1'b0, '0);
    chk(48'(rd[7:0]), 48'(STAT_RST));
    wb(8'h40, 1'b1, 32'hffff_ffff);
    wb(8'h40, 1'b0, '0);
    chk(48'(rd), 48'h0);
    wb(WB_IMASK, 1'b1, 32'h1);
  endtask : t_regs

  task automatic t_pio();
    issue(CMD_WSE, 48'ha1b2_c3d4_e5f6, 16'h0001, 8'h00, -1);
    words(256);
    wait_done();
    chk(48'(wcnt), 48'd256);
    stat(8'h00);
    wb(WB_CTRL, 1'b0, '0);
    chk(48'(rd[8:0]), 48'(CMD_WSE));
    chk(48'(irq), 48'h1);
    wb(WB_ISTAT, 1'b1, 32'h1);
    @(posedge mclk_i);
    chk(48'(irq), 48'h0);
  endtask : t_pio

  // error in the second sector; the carry crosses the low address byte
  task automatic t_pio_err();
    issue(CMD_WSE, 48'h7f00_0000_00ff, 16'h0002, 8'h00, 300);
    words(301);
    wait_done();
    chk(48'(rd[1:0]), 48'h3);
    chk(48'(wcnt), 48'd301);
    stat(8'h01);
    wb(WB_FLO, 1'b0, '0);
    chk(48'(rd), 48'h0000_0100);
    wb(WB_FHI, 1'b0, '0);
    chk(48'(rd[15:0]), 48'h7f00);
    wb(WB_ISTAT, 1'b1, 32'h1);
    @(posedge mclk_i);
    chk(48'(irq), 48'h0);
  endtask : t_pio_err

  task automatic t_strm_cont();
    issue(CMD_WSTR, 48'h0000_0000_1000, 16'h0001, 8'h43, 10);
    words(256);
    wait_done();
    chk(48'(rd[1:0]), 48'h3);
    chk(48'(wcnt), 48'd256);
    stat(8'h20);
    chk(48'(sid), 48'h3);
  endtask : t_strm_cont

  task automatic t_flush();
    int k;
    issue(CMD_WSTR, 48'h0000_0000_2000, 16'h0001, 8'h25, -1);
    words(256);
    k = 0;
    while (fl_req !== 1'b1 && k < 200) begin
      @(posedge mclk_i);
      k++;
    end
    chk(48'(fl_req), 48'h1);
    repeat (20) @(posedge mclk_i);
    wb(WB_ISTAT, 1'b0, '0);
    chk(48'(rd[0]), 48'h0);
    fl_done <= 1'b1;
    wait_done();
    fl_done <= 1'b0;
    chk(48'(sid), 48'h5);
    stat(8'h00);
  endtask : t_flush

  // host stops sending; the time limit must end the command
  task automatic t_tmo();
    issue(CMD_WSTR, 48'h0000_0000_3000, 16'h0001, 8'h40, -1);
    words(10);
    wait_done();
    chk(48'(wcnt), 48'd10);
    stat(8'h20);
  endtask : t_tmo

  // stream without continue stops at the failing word; unknown opcode aborts at once
  task automatic t_abort();
    issue(CMD_WSTR, 48'h0000_0000_4000, 16'h0002, 8'h00, 5);
    words(6);
    wait_done();
    chk(48'(rd[1:0]), 48'h3);
    chk(48'(wcnt), 48'd6);
    stat(8'h01);
    wb(WB_FLO, 1'b0, '0);
    chk(48'(rd), 48'h0000_4000);
    issue(8'h55, 48'h0, 16'h0001, 8'h00, -1);
    wait_done();
    chk(48'(rd[1:0]), 48'h3);
    chk(48'(wcnt), 48'd0);
    stat(8'h01);
  endtask : t_abort

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  initial begin
    nrst_i = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    wdat = '0;
    fl_done = 1'b0;
    wcnt = 0;
    err_idx = -1;
    base = '0;
    n_errors = 0;
    comparisons = 0;
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    t_regs();
    t_pio();
    t_pio_err();
    t_strm_cont();
    t_flush();
    t_tmo();
    t_abort();
    test_done();
  end
endmodule : xwc_test
